// >>> tb/serial_host_model.sv
// host-side serial master model: link clock, chip select, resync and data line
module serial_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdio_o,
  output logic      resync_o,
  input  wire logic sdio_i,
  input  wire logic pin_i,
  input  wire logic oe_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclk_o   = 1'b0;
    cs_n_o   = 1'b1;
    sdio_o   = 1'b0;
    resync_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link clock stands low between frames, 32 ns period inside them
  task automatic pulse(input int n);
    repeat (n)
    begin
      sclk_o = 1'b0;
      #16;
      sclk_o = 1'b1;
      #16;
    end
    sclk_o = 1'b0;
  endtask : pulse

  // the synchroniser needs edges after the level drops too
  task automatic resync();
    resync_o = 1'b1;
    pulse(4);
    resync_o = 1'b0;
    pulse(3);
  endtask : resync

  ////////////////////////////////////////////////////////////////////////////////
  // cut stops the frame early (0 = whole frame); gap lifts chip select before that bit
  task automatic frame(input logic [7:0] ins, input logic lsb, input logic sep,
                       input logic [31:0] wd, input int cut, input int gap,
                       output logic [31:0] rd, output logic gap_oe);
    int total;
    int pos;
    total  = 8 + 8 * (int'(ins[6:5]) + 1);
    rd     = '0;
    gap_oe = 1'b0;
    cs_n_o = 1'b0;
    for (int i = 0; i < total && (cut == 0 || i < cut); i++)
    begin
      if (i == gap)
      begin
        cs_n_o = 1'b1;
        pulse(2);
        #16;
        gap_oe = oe_i;
        // select returns with the clock high: the next falling edge re-drives the held bit
        sclk_o = 1'b1;
        #16;
        cs_n_o = 1'b0;
      end
      pos    = lsb ? i % 8 : 7 - i % 8;
      sclk_o = 1'b0;
      // while the device talks the line is released: a toggling pattern stands on it
      if (i < 8) sdio_o = ins[pos];
      else if (!ins[7]) sdio_o = wd[8 * (i / 8 - 1) + pos];
      else sdio_o = ~sdio_o;
      #16;
      if (ins[7] && i >= 8) rd[8 * (i / 8 - 1) + pos] = sep ? pin_i : sdio_i;
      sclk_o = 1'b1;
      #16;
    end
    sclk_o = 1'b0;
    #16;
    cs_n_o = 1'b1;
    #16;
  endtask : frame
endmodule : serial_host_model

// >>> tb/tb_serial_control_port.sv
// self-checking bench of the serial control port against a host model
module tb_serial_control_port;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        rst_i;
  logic        sclk, cs_n, host_sdio, resync, sdio_w, pin_w;
  logic        sdio_o, sdio_oe, pin_o, pin_oe;
  logic [4:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_valid, wr_ready, overrun, overrun_clr;
  logic        lsb, sep, stall, oflow;
  logic [3:0]  pcnt = 4'h0;
  logic [7:0]  exp_reg [26];
  logic [12:0] q [$];
  logic [4:0]  a;
  logic [31:0] d;
  int          fails, check_count, n, keep;
  int          seed = 32'h73D0;

  always #2.5 clk_i = ~clk_i;
  assign sdio_w = sdio_oe ? sdio_o : host_sdio;
  assign pin_w  = pin_oe ? pin_o : host_sdio;

  serial_control_port uut (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_w),
    .sdio_o(sdio_o), .sdio_oe_o(sdio_oe), .serial_data_output_pin_o(pin_o),
    .serial_data_output_pin_oe_o(pin_oe), .port_resync_input_i(resync),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .overrun_o(overrun), .overrun_clr_i(overrun_clr)
  );

  serial_host_model host (
    .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(host_sdio), .resync_o(resync),
    .sdio_i(sdio_w), .pin_i(pin_w), .oe_i(sdio_oe | pin_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [4:0] step(input logic [4:0] p, input logic l);
    if (l) return (p == 5'h19) ? 5'h00 : p + 5'h01;
    return (p == 5'h00) ? 5'h19 : p - 5'h01;
  endfunction : step

  // one frame; models the bank, the stream and the expected read bytes
  task automatic xfer(input logic rw, input logic [4:0] sa, input int cnt,
                      input logic [31:0] wd, input int cut, input int gap);
    logic [31:0] rd;
    logic [31:0] ex;
    logic        g;
    logic [4:0]  p;
    logic        l0;
    logic        s0;
    p  = sa;
    ex = '0;
    l0 = lsb;
    s0 = sep;
    // model runs ahead: stream words can leave before the frame ends
    for (int k = 0; k < cnt && cut == 0; k++)
    begin
      if (!rw && p < 5'h1A)
      begin
        exp_reg[p] = wd[8 * k +: 8];
        if (keep > 0) q.push_back({p, wd[8 * k +: 8]});
        keep--;
        if (p == 5'h00) {sep, lsb} = wd[8 * k + 6 +: 2];
      end
      ex[8 * k +: 8] = (p < 5'h1A) ? exp_reg[p] : 8'h00;
      p = step(p, lsb);
    end
    host.frame({rw, 2'(cnt - 1), sa}, l0, s0, wd, cut, gap, rd, g);
    if (cut != 0) return;
    if (rw) check(rd, ex);
    if (gap >= 0) check({31'h0, g}, 32'h0);
  endtask : xfer

  task automatic drain();
    for (int i = 0; i < 4000 && q.size() != 0; i++) @(negedge clk_i);
    if (q.size() != 0)
    begin
      fails++;
      print_verdict();
    end
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////////
  // stream sink: a word is taken at the next rising edge when valid and ready stand now
  always @(negedge clk_i)
  begin
    pcnt     = pcnt + 4'h1;
    wr_ready = stall ? 1'b0 : pcnt[1] ^ pcnt[3];
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
    begin
      if (q.size() > 0) check({19'h0, wr_addr, wr_data}, {19'h0, q.pop_front()});
      else if (!oflow) check(32'h1, 32'h0);
    end
  end

  initial
  begin
    {rst_i, overrun_clr, stall, lsb, sep, oflow} = 6'h20;
    fails       = 0;
    check_count = 0;
    keep        = 100000;
    foreach (exp_reg[i]) exp_reg[i] = 8'h00;
    repeat (3) @(negedge clk_i);
    // the link side enters reset at once but leaves it only with serial edges running
    host.pulse(3);
    @(negedge clk_i);
    rst_i = 1'b0;
    host.pulse(3);
    xfer(1'b1, 5'h03, 4, 32'h0, 0, -1);
    xfer(1'b1, 5'h1C, 1, 32'h0, 0, -1);
    for (int t = 0; t < 12; t++)
    begin
      n = 1 + $unsigned($random(seed)) % 4;
      a = 5'(n + $unsigned($random(seed)) % (26 - n));
      d = $random(seed);
      xfer(1'b0, a, n, d, 0, -1);
      xfer(1'b1, a, n, 32'h0, 0, -1);
    end
    xfer(1'b0, 5'h02, 2, 32'h5AC3, 0, -1);
    xfer(1'b1, 5'h00, 2, 32'h0, 0, -1);
    xfer(1'b0, 5'h00, 1, 32'h40, 0, -1);
    xfer(1'b1, 5'h19, 2, 32'h0, 0, -1);
    d = $random(seed);
    xfer(1'b0, 5'h05, 3, d, 0, -1);
    xfer(1'b1, 5'h05, 3, 32'h0, 0, -1);
    xfer(1'b0, 5'h00, 1, 32'hC0, 0, -1);
    xfer(1'b1, 5'h04, 4, 32'h0, 0, 12);
    xfer(1'b0, 5'h00, 1, 32'h00, 0, -1);
    xfer(1'b1, 5'h04, 4, 32'h0, 0, 20);
    xfer(1'b0, 5'h03, 1, 32'hA5, 12, -1);
    host.resync();
    xfer(1'b1, 5'h03, 2, 32'h0, 0, -1);
    drain();
    // fill the stream while the sink stalls, until bytes are lost
    stall = 1'b1;
    oflow = 1'b1;
    keep  = 16;
    repeat (5) xfer(1'b0, 5'h08, 4, $random(seed), 0, -1);
    repeat (20) @(negedge clk_i);
    check({31'h0, overrun}, 32'h1);
    stall = 1'b0;
    drain();
    repeat (200) @(negedge clk_i);
    overrun_clr = 1'b1;
    @(negedge clk_i);
    overrun_clr = 1'b0;
    @(negedge clk_i);
    check({31'h0, overrun}, 32'h0);
    oflow = 1'b0;
    keep  = 100000;
    xfer(1'b1, 5'h08, 4, 32'h0, 0, -1);
    drain();
    print_verdict();
  end
endmodule : tb_serial_control_port

// >>> verilog/serial_control_port.sv
// serial control port: link-side shifter, register bank, write stream fifo

////////////////////////////////////////////////////////////////////////////////
module write_fifo #(
  parameter int WIDTH = serial_ctrl_pkg::WORD_W,
  parameter int DEPTH = serial_ctrl_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic             push, load;

  // the output word is kept in its own stage so the outputs come from flops
  always_comb
  begin
    push           = in_valid_i && (count_reg != FULL_CNT);
    load           = (count_reg != '0) && (!out_valid_reg || out_ready_i);
    mem_next       = mem_reg;
    wr_ptr_next    = wr_ptr_reg;
    rd_ptr_next    = rd_ptr_reg;
    count_next     = count_reg;
    out_valid_next = out_valid_reg;
    out_data_next  = out_data_reg;
    if (out_valid_reg && out_ready_i)
      out_valid_next = 1'b0;
    if (load)
    begin
      out_data_next  = mem_reg[rd_ptr_reg];
      out_valid_next = 1'b1;
      rd_ptr_next    = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + AW'(1);
    end
    if (push)
    begin
      mem_next[wr_ptr_reg] = in_data_i;
      wr_ptr_next          = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + AW'(1);
    end
    count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(load);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= '0;
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else
    begin
      mem_reg       <= mem_next;
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      count_reg     <= count_next;
      out_valid_reg <= out_valid_next;
      out_data_reg  <= out_data_next;
    end
  end

  assign in_ready_o  = (count_reg != FULL_CNT);
  assign out_valid_o = out_valid_reg;
  assign out_data_o  = out_data_reg;

endmodule : write_fifo

////////////////////////////////////////////////////////////////////////////////
module serial_control_port #(
  parameter int FIFO_DEPTH = serial_ctrl_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        sdio_i,
  output logic             sdio_o,
  output logic             sdio_oe_o,
  output logic             serial_data_output_pin_o,
  output logic             serial_data_output_pin_oe_o,
  input  wire logic        port_resync_input_i,
  output logic [4:0]       wr_addr_o,
  output logic [7:0]       wr_data_o,
  output logic             wr_valid_o,
  input  wire logic        wr_ready_i,
  output logic             overrun_o,
  input  wire logic        overrun_clr_i
);
  ////////////////////////////////////////////////////////////////////////////
  // link domain: reset release and resync level brought onto the serial clock
  logic lrst_meta_reg, lrst_reg, rsync_meta_reg, rsync_reg;

  always_ff @(posedge sclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lrst_meta_reg  <= 1'b1;
      lrst_reg       <= 1'b1;
      rsync_meta_reg <= 1'b0;
      rsync_reg      <= 1'b0;
    end
    else
    begin
      lrst_meta_reg  <= 1'b0;
      lrst_reg       <= lrst_meta_reg;
      rsync_meta_reg <= port_resync_input_i;
      rsync_reg      <= rsync_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: rising-edge shifter and register bank
  serial_ctrl_pkg::phase_t phase_reg, phase_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next, sh;
  logic       rw_reg, rw_next;
  logic [1:0] left_reg, left_next;
  logic [4:0] addr_reg, addr_next, addr_step;
  logic [7:0] regs_reg [serial_ctrl_pkg::REG_COUNT];
  logic [7:0] regs_next [serial_ctrl_pkg::REG_COUNT];
  logic       req_tgl_reg, req_tgl_next, drop_tgl_reg, drop_tgl_next;
  logic [4:0] hold_addr_reg, hold_addr_next;
  logic [7:0] hold_data_reg, hold_data_next;
  logic       ack_meta_reg, ack_sync_reg, ack_tgl_reg;
  logic       lsb_first, input_only, busy, byte_end, addr_ok;

  always_comb
  begin
    lsb_first      = regs_reg[serial_ctrl_pkg::CFG_ADDR][serial_ctrl_pkg::LSB_FIRST_BIT];
    input_only     = regs_reg[serial_ctrl_pkg::CFG_ADDR][serial_ctrl_pkg::INPUT_ONLY_BIT];
    busy           = req_tgl_reg != ack_sync_reg;
    addr_ok        = addr_reg <= serial_ctrl_pkg::LAST_ADDR;
    byte_end       = bit_cnt_reg == serial_ctrl_pkg::BIT_LAST;
    // order follows the live config bit, so a write to it acts at once
    sh             = lsb_first ? {sdio_i, shift_reg[7:1]} : {shift_reg[6:0], sdio_i};
    if (lsb_first)
      addr_step = (addr_reg == serial_ctrl_pkg::LAST_ADDR) ?
                  serial_ctrl_pkg::FIRST_ADDR : addr_reg + 5'h01;
    else
      addr_step = (addr_reg == serial_ctrl_pkg::FIRST_ADDR) ?
                  serial_ctrl_pkg::LAST_ADDR : addr_reg - 5'h01;
    phase_next     = phase_reg;
    bit_cnt_next   = bit_cnt_reg;
    shift_next     = shift_reg;
    rw_next        = rw_reg;
    left_next      = left_reg;
    addr_next      = addr_reg;
    regs_next      = regs_reg;
    req_tgl_next   = req_tgl_reg;
    drop_tgl_next  = drop_tgl_reg;
    hold_addr_next = hold_addr_reg;
    hold_data_next = hold_data_reg;
    if (rsync_reg)
    begin
      phase_next   = serial_ctrl_pkg::PH_INSTR;
      bit_cnt_next = serial_ctrl_pkg::BIT_FIRST;
    end
    else if (!cs_n_i)
    begin
      shift_next   = sh;
      bit_cnt_next = bit_cnt_reg + 3'h1;
      if (byte_end && phase_reg == serial_ctrl_pkg::PH_INSTR)
      begin
        rw_next    = sh[serial_ctrl_pkg::RW_BIT];
        left_next  = sh[serial_ctrl_pkg::CNT_HI:serial_ctrl_pkg::CNT_LO];
        addr_next  = sh[serial_ctrl_pkg::ADDR_HI:0];
        phase_next = serial_ctrl_pkg::PH_DATA;
      end
      else if (byte_end)
      begin
        if (!rw_reg && addr_ok)
        begin
          regs_next[addr_reg] = sh;
          // a byte that arrives while the previous one still crosses is lost
          if (busy)
            drop_tgl_next = ~drop_tgl_reg;
          else
          begin
            hold_addr_next = addr_reg;
            hold_data_next = sh;
            req_tgl_next   = ~req_tgl_reg;
          end
        end
        addr_next = addr_step;
        left_next = left_reg - 2'h1;
        if (left_reg == serial_ctrl_pkg::LEFT_NONE)
          phase_next = serial_ctrl_pkg::PH_INSTR;
      end
    end
  end

  always_ff @(posedge sclk_i or posedge lrst_reg)
  begin
    if (lrst_reg)
    begin
      phase_reg     <= serial_ctrl_pkg::PH_INSTR;
      bit_cnt_reg   <= serial_ctrl_pkg::BIT_FIRST;
      shift_reg     <= 8'h00;
      rw_reg        <= 1'b0;
      left_reg      <= serial_ctrl_pkg::LEFT_NONE;
      addr_reg      <= serial_ctrl_pkg::FIRST_ADDR;
      for (int i = 0; i < serial_ctrl_pkg::REG_COUNT; i++)
        regs_reg[i] <= serial_ctrl_pkg::REG_RESET;
      req_tgl_reg   <= 1'b0;
      drop_tgl_reg  <= 1'b0;
      hold_addr_reg <= 5'h00;
      hold_data_reg <= 8'h00;
      ack_meta_reg  <= 1'b0;
      ack_sync_reg  <= 1'b0;
    end
    else
    begin
      phase_reg     <= phase_next;
      bit_cnt_reg   <= bit_cnt_next;
      shift_reg     <= shift_next;
      rw_reg        <= rw_next;
      left_reg      <= left_next;
      addr_reg      <= addr_next;
      regs_reg      <= regs_next;
      req_tgl_reg   <= req_tgl_next;
      drop_tgl_reg  <= drop_tgl_next;
      hold_addr_reg <= hold_addr_next;
      hold_data_reg <= hold_data_next;
      ack_meta_reg  <= ack_tgl_reg;
      ack_sync_reg  <= ack_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: falling-edge read driver
  logic [7:0] rd_byte;
  logic [2:0] rd_idx;
  logic       reading, out_bit_reg, out_bit_next;
  logic       sdio_oe_reg, sdio_oe_next, sdo_oe_reg, sdo_oe_next;

  always_comb
  begin
    rd_byte      = addr_ok ? regs_reg[addr_reg] : 8'h00;
    rd_idx       = lsb_first ? bit_cnt_reg : serial_ctrl_pkg::BIT_LAST - bit_cnt_reg;
    reading      = (phase_reg == serial_ctrl_pkg::PH_DATA) && rw_reg && !rsync_reg;
    out_bit_next = rd_byte[rd_idx];
    sdio_oe_next = reading && !input_only;
    sdo_oe_next  = reading && input_only;
  end

  // chip select clears the enables at once: the serial clock may be stopped
  always_ff @(negedge sclk_i or posedge lrst_reg or posedge cs_n_i)
  begin
    if (lrst_reg || cs_n_i)
    begin
      out_bit_reg <= 1'b0;
      sdio_oe_reg <= 1'b0;
      sdo_oe_reg  <= 1'b0;
    end
    else
    begin
      out_bit_reg <= out_bit_next;
      sdio_oe_reg <= sdio_oe_next;
      sdo_oe_reg  <= sdo_oe_next;
    end
  end

  assign sdio_o                      = out_bit_reg;
  assign sdio_oe_o                   = sdio_oe_reg;
  assign serial_data_output_pin_o    = out_bit_reg;
  assign serial_data_output_pin_oe_o = sdo_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: toggle handshake into the fifo, overrun flag
  logic req_meta_reg, req_sync_reg, ack_tgl_next;
  logic drop_meta_reg, drop_sync_reg, drop_seen_reg;
  logic overrun_reg, overrun_next;
  logic pending, fifo_ready;

  always_comb
  begin
    pending      = req_sync_reg != ack_tgl_reg;
    // hold registers stay still until the ack returns to the link side
    ack_tgl_next = (pending && fifo_ready) ? ~ack_tgl_reg : ack_tgl_reg;
    overrun_next = (drop_sync_reg != drop_seen_reg) || (overrun_reg && !overrun_clr_i);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_meta_reg  <= 1'b0;
      req_sync_reg  <= 1'b0;
      ack_tgl_reg   <= 1'b0;
      drop_meta_reg <= 1'b0;
      drop_sync_reg <= 1'b0;
      drop_seen_reg <= 1'b0;
      overrun_reg   <= 1'b0;
    end
    else
    begin
      req_meta_reg  <= req_tgl_reg;
      req_sync_reg  <= req_meta_reg;
      ack_tgl_reg   <= ack_tgl_next;
      drop_meta_reg <= drop_tgl_reg;
      drop_sync_reg <= drop_meta_reg;
      drop_seen_reg <= drop_sync_reg;
      overrun_reg   <= overrun_next;
    end
  end

  assign overrun_o = overrun_reg;

  write_fifo #(
    .WIDTH (serial_ctrl_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pending),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({hold_addr_reg, hold_data_reg}),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  ({wr_addr_o, wr_data_o})
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks on the link logic
  logic       go, instr_end, data_end;
  logic [1:0] cnt_field;
  logic [4:0] addr_field;
  logic       rw_field;

  assign go         = !cs_n_i && !rsync_reg;
  assign instr_end  = go && byte_end && phase_reg == serial_ctrl_pkg::PH_INSTR;
  assign data_end   = go && byte_end && phase_reg == serial_ctrl_pkg::PH_DATA;
  assign cnt_field  = sh[serial_ctrl_pkg::CNT_HI:serial_ctrl_pkg::CNT_LO];
  assign addr_field = sh[serial_ctrl_pkg::ADDR_HI:0];
  assign rw_field   = sh[serial_ctrl_pkg::RW_BIT];

  instr_to_data_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg)
    instr_end |=> phase_reg == serial_ctrl_pkg::PH_DATA && bit_cnt_reg == 3'h0)
    else $error("instruction byte did not open the data phase");

  count_decode_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg)
    instr_end |=> left_reg == $past(cnt_field))
    else $error("byte count field decoded wrongly");

  rw_decode_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg)
    instr_end |=> rw_reg == $past(rw_field))
    else $error("direction bit decoded wrongly");

  addr_start_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg)
    instr_end |=> addr_reg == $past(addr_field))
    else $error("start address decoded wrongly");

  cycle_end_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg)
    data_end && left_reg == 2'h0 |=> phase_reg == serial_ctrl_pkg::PH_INSTR)
    else $error("cycle did not return to instruction phase");

  addr_down_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg)
    data_end && !lsb_first && addr_reg != 5'h00 |=> addr_reg == $past(addr_reg) - 5'h01)
    else $error("msb-first address did not decrement");

  resync_abort_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg)
    rsync_reg |=> phase_reg == serial_ctrl_pkg::PH_INSTR && bit_cnt_reg == 3'h0)
    else $error("resync did not abort the cycle");

  suspend_hold_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg)
    cs_n_i && !rsync_reg |=> $stable(bit_cnt_reg) && $stable(phase_reg))
    else $error("cycle moved while chip select was high");

  read_drive_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg || cs_n_i)
    reading && $past(reading) && $stable(bit_cnt_reg) |-> out_bit_reg == out_bit_next)
    else $error("read bit not driven from the falling edge");

  write_store_a: assert property (
    @(posedge sclk_i) disable iff (lrst_reg)
    data_end && !rw_reg && addr_reg == 5'h01 |=> regs_reg[1] == $past(sh))
    else $error("write byte not stored");

  multi_write_c: cover property (@(posedge sclk_i) data_end && !rw_reg && left_reg == 2'h3);
  read_cycle_c:  cover property (@(posedge sclk_i) data_end && rw_reg);
  resync_c:      cover property (@(posedge sclk_i) rsync_reg && phase_reg == serial_ctrl_pkg::PH_DATA);
  lsb_instr_c:   cover property (@(posedge sclk_i) instr_end && lsb_first);

endmodule : serial_control_port

// >>> verilog/serial_ctrl_pkg.sv
// constants and types shared by the serial control port
package serial_ctrl_pkg;

  localparam int          BYTE_W         = 8;
  localparam int          ADDR_W         = 5;
  localparam int          WORD_W         = ADDR_W + BYTE_W;
  localparam int          REG_COUNT      = 26;
  localparam int          FIFO_DEPTH     = 16;

  // instruction byte fields
  localparam int          RW_BIT         = 7;
  localparam int          CNT_HI         = 6;
  localparam int          CNT_LO         = 5;
  localparam int          ADDR_HI        = 4;

  // port configuration register and its bits, bank address range and reset value
  localparam logic [4:0]  CFG_ADDR       = 5'h00;
  localparam int          LSB_FIRST_BIT  = 6;
  localparam int          INPUT_ONLY_BIT = 7;
  localparam logic [4:0]  LAST_ADDR      = 5'h19;
  localparam logic [4:0]  FIRST_ADDR     = 5'h00;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  localparam logic [2:0]  BIT_FIRST      = 3'h0;
  localparam logic [2:0]  BIT_LAST       = 3'h7;
  localparam logic [1:0]  LEFT_NONE      = 2'h0;

  typedef enum logic [0:0] {
    PH_INSTR = 1'b0,
    PH_DATA  = 1'b1
  } phase_t;

endpackage : serial_ctrl_pkg
